/* File: hw/pmt_pkg.sv */
// Package: constants, register map and state types of the period timer
package pmt_pkg;

    // ============================================================
    // Clocking
    localparam int unsigned CLK_FREQ_HZ   = 20000000;
    localparam int unsigned OSC_PER_INSTR = 4;
    localparam int unsigned QDIV_W        = 2;

    // ============================================================
    // Register byte offsets (APB, one word each)
    localparam logic [7:0] OFS_COUNT = 8'h00;
    localparam logic [7:0] OFS_LIMIT = 8'h04;
    localparam logic [7:0] OFS_CTRL  = 8'h08;
    localparam logic [7:0] OFS_FLAG  = 8'h0C;
    localparam logic [7:0] OFS_MASK  = 8'h10;

    // ============================================================
    // Field positions of timer_control
    localparam int unsigned CTRL_PRE_LSB  = 0;
    localparam int unsigned CTRL_RUN_BIT  = 2;
    localparam int unsigned CTRL_POST_LSB = 3;

    // Field position of the period match flag and its mask
    localparam int unsigned FLAG_BIT = 0;

    // ============================================================
    // Reset values
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [7:0] LIMIT_RST = 8'hFF;
    localparam logic [1:0] PRE_RST   = 2'h0;
    localparam logic [3:0] POST_RST  = 4'h0;

    // Prescaler terminal counts (ratio minus one)
    localparam logic [3:0] PRE_TC_1  = 4'h0;
    localparam logic [3:0] PRE_TC_4  = 4'h3;
    localparam logic [3:0] PRE_TC_16 = 4'hF;

    // ============================================================
    // Types
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } pmt_apb_req_t;

    typedef struct packed {
        logic [QDIV_W-1:0] cnt;
    } pmt_div_state_t;

    typedef struct packed {
        logic [7:0]  count;
        logic [7:0]  limit;
        logic        run;
        logic [1:0]  pre_sel;
        logic [3:0]  post_sel;
        logic [3:0]  pre_cnt;
        logic [3:0]  post_cnt;
        logic        flag;
        logic        mask;
        logic [31:0] prdata;
    } pmt_state_t;

endpackage

/* File: hw/pmt_tick_div.sv */
// Free-running divider giving a one-cycle tick every DIV clocks
`timescale 1ns/1ns
`default_nettype none

module pmt_tick_div #(
    parameter int unsigned W   = 2,
    parameter int unsigned DIV = 4
) (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Tick out
    output logic      tick
);

    localparam logic [W-1:0] TC = W'(DIV - 1);

    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;

    always_comb begin
        cnt_nxt = (cnt_r == TC) ? '0 : W'(cnt_r + 1'b1);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign tick = (cnt_r == TC);

    a_tick_period : assert property (@(posedge pclk) disable iff (!presetn)
        tick |=> !tick [*3] ##1 tick)
        else $error("instruction tick period is not four clocks");

endmodule
`default_nettype wire

/* File: hw/pmt_timer.sv */
// Period match timer with prescaler, postscaler and APB registers
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/1ns
`default_nettype none

// Function
// - The count clock is the instruction clock, pclk divided by four, fed through the prescaler.
// - The prescaler divides by 1, 4 or 16 and its output increments the 8-bit count.
// - Count and period limit are each 8 bits wide.
// - The count climbs from 00h and is compared with the limit at all times.
// - On a match the count returns to 00h on the next increment instead of passing the limit.
// - Each match advances the postscaler, which divides matches by 1 to 16.
// - The postscaler output sets the period match flag.
// - Software can read and write the count and the limit at any time.
// - Reset loads the count with 00h and the limit with FFh.
// - The timer counts only while the run bit is one.
// - Writes to the count or control register and any reset clear both scaler counters.
// - A control write leaves the count unchanged.

module pmt_timer (
    // Clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // APB request
    input  wire pmt_pkg::pmt_apb_req_t apb_req,
    // APB answer
    output logic [31:0]               prdata,
    output logic                      pready,
    output logic                      pslverr,
    // Interrupt
    output logic                      irq
);

    // ============================================================
    // State
    pmt_pkg::pmt_state_t st_r;
    pmt_pkg::pmt_state_t st_nxt;

    logic       q_tick;
    logic       setup;
    logic       access;
    logic       wr_count;
    logic       wr_limit;
    logic       wr_ctrl;
    logic       wr_flag;
    logic       wr_mask;
    logic       rd_flag;
    logic       mapped;
    logic [3:0] pre_tc;
    logic       pre_tick;
    logic       inc_en;
    logic       match;
    logic       post_fire;
    logic       flag_clr;
    logic [31:0] rd_mux;

    // ============================================================
    // Instruction clock tick
    pmt_tick_div #(
        .W   (pmt_pkg::QDIV_W),
        .DIV (pmt_pkg::OSC_PER_INSTR)
    ) u_qdiv (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (q_tick)
    );

    // ============================================================
    // Bus decode
    always_comb begin
        setup  = apb_req.psel && !apb_req.penable;
        access = apb_req.psel && apb_req.penable;
        mapped = (apb_req.paddr == pmt_pkg::OFS_COUNT) ||
                 (apb_req.paddr == pmt_pkg::OFS_LIMIT) ||
                 (apb_req.paddr == pmt_pkg::OFS_CTRL)  ||
                 (apb_req.paddr == pmt_pkg::OFS_FLAG)  ||
                 (apb_req.paddr == pmt_pkg::OFS_MASK);
        wr_count = access && apb_req.pwrite &&
                   (apb_req.paddr == pmt_pkg::OFS_COUNT);
        wr_limit = access && apb_req.pwrite &&
                   (apb_req.paddr == pmt_pkg::OFS_LIMIT);
        wr_ctrl  = access && apb_req.pwrite &&
                   (apb_req.paddr == pmt_pkg::OFS_CTRL);
        wr_flag  = access && apb_req.pwrite &&
                   (apb_req.paddr == pmt_pkg::OFS_FLAG);
        wr_mask  = access && apb_req.pwrite &&
                   (apb_req.paddr == pmt_pkg::OFS_MASK);
        rd_flag  = access && !apb_req.pwrite &&
                   (apb_req.paddr == pmt_pkg::OFS_FLAG);
    end

    // Read data mux, sampled in the setup cycle
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (apb_req.paddr)
            pmt_pkg::OFS_COUNT: begin
                rd_mux[7:0] = st_r.count;
            end
            pmt_pkg::OFS_LIMIT: begin
                rd_mux[7:0] = st_r.limit;
            end
            pmt_pkg::OFS_CTRL: begin
                rd_mux[pmt_pkg::CTRL_PRE_LSB +: 2]  = st_r.pre_sel;
                rd_mux[pmt_pkg::CTRL_RUN_BIT]       = st_r.run;
                rd_mux[pmt_pkg::CTRL_POST_LSB +: 4] = st_r.post_sel;
            end
            pmt_pkg::OFS_FLAG: begin
                rd_mux[pmt_pkg::FLAG_BIT] = st_r.flag;
            end
            pmt_pkg::OFS_MASK: begin
                rd_mux[pmt_pkg::FLAG_BIT] = st_r.mask;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    // ============================================================
    // Timer datapath
    always_comb begin
        case (st_r.pre_sel)
            2'h0:    pre_tc = pmt_pkg::PRE_TC_1;
            2'h1:    pre_tc = pmt_pkg::PRE_TC_4;
            default: pre_tc = pmt_pkg::PRE_TC_16;
        endcase
        // Scaler clears and count writes suppress the increment
        pre_tick  = q_tick && st_r.run && (st_r.pre_cnt == pre_tc);
        inc_en    = pre_tick && !wr_count && !wr_ctrl;
        match     = (st_r.count == st_r.limit);
        post_fire = inc_en && match &&
                    (st_r.post_cnt == st_r.post_sel);
        flag_clr  = rd_flag ||
                    (wr_flag && !apb_req.pwdata[pmt_pkg::FLAG_BIT]);
    end

    always_comb begin
        st_nxt = st_r;

        // Prescaler counter
        if (wr_count || wr_ctrl) begin
            st_nxt.pre_cnt = 4'h0;
        end else if (q_tick && st_r.run) begin
            st_nxt.pre_cnt = pre_tick ? 4'h0 : 4'(st_r.pre_cnt + 4'h1);
        end

        // Count register
        if (wr_count) begin
            st_nxt.count = apb_req.pwdata[7:0];
        end else if (inc_en) begin
            if (match) begin
                st_nxt.count = pmt_pkg::COUNT_RST;
            end else begin
                st_nxt.count = 8'(st_r.count + 8'h01);
            end
        end

        // Postscaler counter
        if (wr_count || wr_ctrl) begin
            st_nxt.post_cnt = 4'h0;
        end else if (inc_en && match) begin
            st_nxt.post_cnt = post_fire ? 4'h0
                                        : 4'(st_r.post_cnt + 4'h1);
        end

        // Limit register
        if (wr_limit) begin
            st_nxt.limit = apb_req.pwdata[7:0];
        end

        // Control register, count untouched
        if (wr_ctrl) begin
            st_nxt.pre_sel  = apb_req.pwdata[pmt_pkg::CTRL_PRE_LSB +: 2];
            st_nxt.run      = apb_req.pwdata[pmt_pkg::CTRL_RUN_BIT];
            st_nxt.post_sel = apb_req.pwdata[pmt_pkg::CTRL_POST_LSB +: 4];
        end

        // Mask register
        if (wr_mask) begin
            st_nxt.mask = apb_req.pwdata[pmt_pkg::FLAG_BIT];
        end

        // Sticky flag, set wins over clear
        if (post_fire) begin
            st_nxt.flag = 1'b1;
        end else if (flag_clr) begin
            st_nxt.flag = 1'b0;
        end

        // Read data captured in setup cycle
        if (setup) begin
            st_nxt.prdata = mapped ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r          <= '0;
            st_r.count    <= pmt_pkg::COUNT_RST;
            st_r.limit    <= pmt_pkg::LIMIT_RST;
            st_r.pre_sel  <= pmt_pkg::PRE_RST;
            st_r.post_sel <= pmt_pkg::POST_RST;
            st_r.pre_cnt  <= 4'h0;
            st_r.post_cnt <= 4'h0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ============================================================
    // Outputs
    assign prdata  = st_r.prdata;
    assign pready  = access;
    assign pslverr = access && !mapped;
    assign irq     = st_r.flag && st_r.mask;

    // ============================================================
    // Checks
    sequence s_match_step;
        inc_en && match && !wr_limit;
    endsequence

    sequence s_wrapped;
        st_r.count == 8'h00;
    endsequence

    property p_wrap;
        @(posedge pclk) disable iff (!presetn)
        s_match_step |=> s_wrapped;
    endproperty

    a_count_wrap : assert property (p_wrap)
        else $error("count did not return to zero after match");

    a_count_step : assert property (@(posedge pclk) disable iff (!presetn)
        inc_en && !match |=> st_r.count == 8'($past(st_r.count) + 8'h01))
        else $error("count did not increment by one");

    a_stop_hold : assert property (@(posedge pclk) disable iff (!presetn)
        !st_r.run && !wr_count |=> $stable(st_r.count))
        else $error("count moved while stopped");

    a_ctrl_keep : assert property (@(posedge pclk) disable iff (!presetn)
        wr_ctrl |=> $stable(st_r.count) && st_r.pre_cnt == 4'h0
                    && st_r.post_cnt == 4'h0)
        else $error("control write disturbed count or scalers");

    a_count_write : assert property (@(posedge pclk) disable iff (!presetn)
        wr_count |=> st_r.count == $past(apb_req.pwdata[7:0])
                     && st_r.pre_cnt == 4'h0 && st_r.post_cnt == 4'h0)
        else $error("count write not applied or scalers not cleared");

    a_pre_sixteen : assert property (@(posedge pclk) disable iff (!presetn)
        pre_tick && st_r.pre_sel[1] |-> st_r.pre_cnt == 4'hF)
        else $error("1:16 prescale fired early");

    a_post_ratio : assert property (@(posedge pclk) disable iff (!presetn)
        post_fire |-> match && st_r.post_cnt == st_r.post_sel)
        else $error("postscaler fired at the wrong count");

    a_flag_set : assert property (@(posedge pclk) disable iff (!presetn)
        post_fire |=> st_r.flag ##0 irq == st_r.mask)
        else $error("flag not set by postscaler");

    a_flag_hold : assert property (@(posedge pclk) disable iff (!presetn)
        st_r.flag && !flag_clr |=> st_r.flag)
        else $error("flag cleared without software");

endmodule
`default_nettype wire

/* File: bench/test_pmt_timer.sv */
// Self-checking testbench of the period match timer
`timescale 1ns/1ns
`default_nettype none

module test_pmt_timer;
    // ============================================================
    // Signals
    logic                  pclk;
    logic                  presetn;
    pmt_pkg::pmt_apb_req_t apb_req;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  irq;
    int                    error_cnt;
    int                    tests_run;

    pmt_timer pmt_timer_i (
        .pclk    (pclk),
        .presetn (presetn),
        .apb_req (apb_req),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .irq     (irq)
    );

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // ============================================================
    // Common tasks
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    // One APB transfer, entered just after a rising edge
    task automatic apb(input logic wr, input logic [7:0] addr,
                       input logic [31:0] wdata, output logic [31:0] rdata,
                       output logic err);
        int n;
        apb_req.psel    <= 1'b1;
        apb_req.pwrite  <= wr;
        apb_req.paddr   <= addr;
        apb_req.pwdata  <= wdata;
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            error_cnt++;
            stop_test();
        end
        rdata = prdata;
        err = pslverr;
        apb_req.psel    <= 1'b0;
        apb_req.penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        logic [31:0] d;
        logic        e;
        apb(1'b1, addr, data, d, e);
        chk(32'(e), 32'h0);
    endtask

    task automatic rd(input logic [7:0] addr, output logic [31:0] data);
        logic e;
        apb(1'b0, addr, 32'h0, data, e);
    endtask

    task automatic rdc(input logic [7:0] addr, input logic [31:0] exp);
        logic [31:0] d;
        rd(addr, d);
        chk(d, exp);
    endtask

    // ============================================================
    // Scenarios
    task automatic test_reset();
        logic [31:0] d;
        logic        e;
        rdc(pmt_pkg::OFS_COUNT, 32'h00);
        rdc(pmt_pkg::OFS_LIMIT, 32'hFF);
        rdc(pmt_pkg::OFS_CTRL, 32'h00);
        rdc(pmt_pkg::OFS_FLAG, 32'h00);
        chk(32'(irq), 32'h0);
        apb(1'b0, 8'h14, 32'h0, d, e);
        chk(32'(e), 32'h1);
        chk(d, 32'h0);
        $display("Test reset done");
    endtask

    task automatic test_rw();
        wr(pmt_pkg::OFS_LIMIT, 32'h5A);
        rdc(pmt_pkg::OFS_LIMIT, 32'h5A);
        wr(pmt_pkg::OFS_COUNT, 32'hA5);
        rdc(pmt_pkg::OFS_COUNT, 32'hA5);
        wr(pmt_pkg::OFS_LIMIT, 32'h1FF);
        rdc(pmt_pkg::OFS_LIMIT, 32'hFF);
        $display("Test register access done");
    endtask

    task automatic test_hold();
        wr(pmt_pkg::OFS_CTRL, 32'h02);
        wr(pmt_pkg::OFS_COUNT, 32'h33);
        repeat (40) @(posedge pclk);
        rdc(pmt_pkg::OFS_COUNT, 32'h33);
        // Start at 1:16 so no step lands before the read
        wr(pmt_pkg::OFS_CTRL, 32'h06);
        rdc(pmt_pkg::OFS_COUNT, 32'h33);
        wr(pmt_pkg::OFS_CTRL, 32'h00);
        $display("Test stop and hold done");
    endtask

    task automatic test_wrap();
        logic [31:0] d;
        int          over;
        int          top;
        over = 0;
        top = 0;
        wr(pmt_pkg::OFS_LIMIT, 32'h03);
        wr(pmt_pkg::OFS_COUNT, 32'h00);
        wr(pmt_pkg::OFS_CTRL, 32'h04);
        for (int i = 0; i < 30; i++) begin
            rd(pmt_pkg::OFS_COUNT, d);
            if (d > 32'h3) over++;
            if (d == 32'h3) top = 1;
        end
        chk(32'(over), 32'h0);
        chk(32'(top), 32'h1);
        wr(pmt_pkg::OFS_CTRL, 32'h00);
        // Every wrap at 1:1 postscale set the flag; read clears it
        rdc(pmt_pkg::OFS_FLAG, 32'h01);
        $display("Test wrap done");
    endtask

    // Flag delay: 4 clocks a tick, mult ticks a step, 2 steps a match
    task automatic test_ratio(input logic [1:0] pre, input int mult,
                              input logic [3:0] post);
        int exp;
        int m;
        exp = 8 * mult * (int'(post) + 1);
        wr(pmt_pkg::OFS_CTRL, 32'h00);
        wr(pmt_pkg::OFS_COUNT, 32'h00);
        wr(pmt_pkg::OFS_LIMIT, 32'h01);
        rdc(pmt_pkg::OFS_FLAG, 32'h00);
        wr(pmt_pkg::OFS_MASK, 32'h01);
        wr(pmt_pkg::OFS_CTRL, {25'h0, post, 1'b1, pre});
        m = 0;
        while (irq !== 1'b1 && m < 4000) begin
            @(posedge pclk);
            m++;
        end
        if (m >= 4000) begin
            error_cnt++;
            stop_test();
        end
        chk(32'(m >= exp - 5 && m <= exp + 2), 32'h1);
        wr(pmt_pkg::OFS_CTRL, 32'h00);
        repeat (20) @(posedge pclk);
        chk(32'(irq), 32'h1);
        wr(pmt_pkg::OFS_MASK, 32'h00);
        chk(32'(irq), 32'h0);
        wr(pmt_pkg::OFS_MASK, 32'h01);
        chk(32'(irq), 32'h1);
        rdc(pmt_pkg::OFS_FLAG, 32'h01);
        chk(32'(irq), 32'h0);
        $display("Test ratio pre %0d post %0d done", pre, post);
    endtask

    // Reset in mid-run restores count, limit and control
    task automatic test_rerun();
        wr(pmt_pkg::OFS_LIMIT, 32'h22);
        wr(pmt_pkg::OFS_COUNT, 32'h44);
        wr(pmt_pkg::OFS_CTRL, 32'h7E);
        repeat (10) @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc(pmt_pkg::OFS_COUNT, 32'h00);
        rdc(pmt_pkg::OFS_LIMIT, 32'hFF);
        rdc(pmt_pkg::OFS_CTRL, 32'h00);
        $display("Test mid-run reset done");
    endtask

    // ============================================================
    // Main sequence
    initial begin
        presetn = 1'b0;
        apb_req = '0;
        error_cnt = 0;
        tests_run = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        test_reset();
        test_rw();
        test_hold();
        test_wrap();
        test_ratio(2'h0, 1, 4'h0);
        test_ratio(2'h0, 1, 4'h2);
        test_ratio(2'h0, 1, 4'hF);
        test_ratio(2'h1, 4, 4'h1);
        test_ratio(2'h2, 16, 4'h0);
        test_ratio(2'h3, 16, 4'h0);
        test_rerun();
        stop_test();
    end
endmodule

`default_nettype wire
